// ---- hw/fse_pkg.sv ----
// Constants and types shared by the sector erase abort sequencer
package fse_pkg;
  // Clock and operation times
  localparam int unsigned CLOCK_PERIOD_NS = 5;
  localparam int unsigned ERASE_TIME_NS = 20000;
  localparam int unsigned PROG_TIME_NS = 10000;
  localparam logic [11:0] ERASE_CYCLES =
    12'((ERASE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
  localparam logic [11:0] PROG_CYCLES =
    12'((PROG_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
  localparam logic [11:0] CNT_LAST = 12'h001;
  // Command codes
  localparam logic [7:0] CMD_PROGRAM = 8'h20;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h40;
  localparam logic [7:0] CMD_ERASE_ABORT = 8'h47;
  // Nonvolatile register area
  localparam logic [15:0] NV_BASE = 16'hffb0;
  localparam int NV_DEPTH = 16;
  localparam logic [7:0] NV_ERASED = 8'hff;
  localparam logic [3:0] NV_PROT_IDX = 4'hd;
  localparam logic [3:0] NV_OPT_IDX = 4'hf;
  localparam int NV_AREA_LSB = 4;
  localparam int SECTOR_LSB = 9;
  localparam int OPT_BACKDOOR_BIT = 7;
  // Bus address layout
  localparam int ADR_W = 19;
  localparam int FLASH_SEL_BIT = 18;
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
  localparam logic [7:0] REG_PROT = 8'h10;
  localparam logic [7:0] REG_OPT = 8'h14;
  localparam logic [7:0] REG_KEY_LO = 8'h18;
  localparam logic [7:0] REG_KEY_HI = 8'h1c;
  localparam logic [7:0] REG_SECURE = 8'h20;
  // Status and interrupt bit positions
  localparam int ST_CBE_BIT = 7;
  localparam int ST_CCF_BIT = 6;
  localparam int ST_ACC_BIT = 4;
  localparam int IRQ_CCF_BIT = 0;
  localparam int IRQ_ACC_BIT = 1;
  // Command write sequence states
  typedef enum logic [3:0] {
    SEQ_LOAD = 4'b0001,
    SEQ_IDLE = 4'b0010,
    SEQ_ARMED = 4'b0100,
    SEQ_READY = 4'b1000
  } fse_seq_t;
  // Engine states
  typedef enum logic [2:0] {
    ENG_IDLE = 3'b001,
    ENG_ERASE = 3'b010,
    ENG_PROG = 3'b100
  } fse_eng_st_t;
endpackage : fse_pkg

// ---- hw/fse_eng_if.sv ----
// Link between the command sequencer and the timing engine
`timescale 1ns/10ps
`default_nettype none
interface fse_eng_if;
  logic start;         // Launch pulse
  logic [7:0] code;    // Command code with start
  logic abort;         // Abort pulse
  logic busy;          // Engine running
  logic erasing;       // Sector erase running
  logic done;          // Completion pulse
  logic cutShort;      // Erase ended early, with done
  modport eng (input start, code, abort, output busy, erasing, done,
    cutShort);
  modport ctl (output start, code, abort, input busy, erasing, done,
    cutShort);
endinterface : fse_eng_if
`default_nettype wire

// ---- hw/fse_engine.sv ----
// Timing engine for erase and program operations
`timescale 1ns/10ps
`default_nettype none
module fse_engine import fse_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Sequencer side
  fse_eng_if.eng eng
);
  // Whole engine state
  typedef struct packed {
    fse_eng_st_t st;
    logic [11:0] cnt;
    logic done;
    logic cutShort;
  } fse_eng_state_t;
  fse_eng_state_t s_reg, s_next;

  // Next state
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.cutShort = 1'b0;
    case (s_reg.st)
      ENG_IDLE: begin
        if (eng.start) begin
          case (eng.code)
            CMD_SECTOR_ERASE: begin
              s_next.st = ENG_ERASE;
              s_next.cnt = ERASE_CYCLES;
            end
            CMD_PROGRAM: begin
              s_next.st = ENG_PROG;
              s_next.cnt = PROG_CYCLES;
            end
            default: s_next.done = 1'b1;
          endcase
        end
      end
      ENG_ERASE: begin
        if (s_reg.cnt == CNT_LAST) begin
          // Normal finish beats a late abort
          s_next.st = ENG_IDLE;
          s_next.done = 1'b1;
        end else if (eng.abort) begin
          s_next.st = ENG_IDLE;
          s_next.done = 1'b1;
          s_next.cutShort = 1'b1;
        end else begin
          s_next.cnt = s_reg.cnt - CNT_LAST;
        end
      end
      ENG_PROG: begin
        if (s_reg.cnt == CNT_LAST) begin
          s_next.st = ENG_IDLE;
          s_next.done = 1'b1;
        end else begin
          s_next.cnt = s_reg.cnt - CNT_LAST;
        end
      end
      default: s_next.st = ENG_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '{st: ENG_IDLE, cnt: 12'h000, done: 1'b0, cutShort: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs to the sequencer
  assign eng.busy = (s_reg.st != ENG_IDLE);
  assign eng.erasing = (s_reg.st == ENG_ERASE);
  assign eng.done = s_reg.done;
  assign eng.cutShort = s_reg.cutShort;
endmodule : fse_engine
`default_nettype wire

// ---- hw/fse_sector_abort.sv ----
// Flash command sequencer with sector erase abort and nonvolatile area
// Overview of operation
// - Abort stops a running sector erase
// - First step: any flash write, ignored
// - Second step: code 47h into command register
// - Writing one to buffer-empty launches command
// - Cut erase sets access error with complete
// - Erase finishing normally leaves access error clear
// - Nonvolatile area: sixteen bytes from FFB0h
// - Protection and option bytes load after reset
// - Eight-byte backdoor key unlocks secure memory
// - Nonvolatile bytes change only by commands
//
// Implementation choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module fse_sector_abort import fse_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Wishbone slave
  input wire logic [ADR_W-1:0] wbAdrI,
  input wire logic [31:0] wbDatI,
  input wire logic [3:0] wbSelI,
  input wire logic wbWeI,
  input wire logic wbCycI,
  input wire logic wbStbI,
  output logic [31:0] wbDatO,
  output logic wbAckO,
  // Interrupt
  output logic irq
);
  // Field positions local to the register map
  localparam int BYTE_W = 8; // Register width in bits
  localparam int LANES = 4; // Byte lanes per bus word
  localparam int KEY_HI_LSB = 32; // Upper half of the key
  localparam int KEY_BYTES = 8; // Backdoor key length
  localparam int REG_OFF_MSB = 7; // Top bit of register offset
  localparam int SECURE_BIT = 0; // Unlock request and state
  localparam int CTRL_LANE = 0; // Lane carrying control bytes

  // Whole sequencer state
  typedef struct packed {
    fse_seq_t seq;                 // Command write sequence
    logic ack;                     // Bus acknowledge
    logic [31:0] datOut;           // Bus read data
    logic [7:0] cmd;               // Command register
    logic [7:0] runCmd;            // Command under way
    logic [15:0] runAddr;          // Address under way
    logic [7:0] runData;           // Data under way
    logic [15:0] flAddr;           // Latched flash address
    logic [7:0] flData;            // Latched flash data
    logic cbe;                     // Command buffer empty
    logic ccf;                     // Command complete
    logic accErr;                  // Access error
    logic [1:0] irqStat;           // Sticky events
    logic [1:0] irqMask;           // Event enables
    logic irq;                     // Interrupt output
    logic [7:0] prot;              // Working protection byte
    logic [7:0] opt;               // Working option byte
    logic [63:0] key;              // Key written by software
    logic unlocked;                // Backdoor match
    logic engStart;                // Engine launch
    logic engAbort;                // Engine abort
    logic [NV_DEPTH-1:0][7:0] nv;  // Nonvolatile bytes
  } fse_state_t;
  fse_state_t s_reg, s_next;

  // Engine link
  fse_eng_if engLink();

  // Timing engine
  fse_engine uEngine (
    .clock(clock),
    .rst_b(rst_b),
    .eng(engLink.eng)
  );

  // Engine inputs straight from state
  assign engLink.start = s_reg.engStart;
  assign engLink.code = s_reg.runCmd;
  assign engLink.abort = s_reg.engAbort;

  // Decoded bus access
  logic access;
  logic wr;
  logic flashSel;
  logic [15:0] flAdr;
  logic [7:0] regOff;
  logic inNvArea;
  logic [7:0] flRead;

  // Bus decode
  always_comb begin
    access = wbCycI & wbStbI & ~s_reg.ack;
    wr = access & wbWeI;
    flashSel = wbAdrI[FLASH_SEL_BIT];
    // Flash byte address drops the word offset bits
    flAdr = wbAdrI[FLASH_SEL_BIT-1:2];
    regOff = wbAdrI[REG_OFF_MSB:0];
    // Only the nonvolatile area is held; rest reads erased
    inNvArea = (flAdr[15:NV_AREA_LSB] == NV_BASE[15:NV_AREA_LSB]);
    flRead = inNvArea ? s_reg.nv[flAdr[NV_AREA_LSB-1:0]] : NV_ERASED;
  end

  // Next state
  always_comb begin
    s_next = s_reg;
    s_next.ack = 1'b0;
    s_next.engStart = 1'b0;
    s_next.engAbort = 1'b0;
    // Buffer frees one cycle after a launch
    if (!s_reg.cbe) begin
      s_next.cbe = 1'b1;
    end

    // Sequence housekeeping before the bus access below
    case (s_reg.seq)
      SEQ_LOAD: begin
        // Working bytes load once reset is released
        s_next.prot = s_reg.nv[NV_PROT_IDX];
        s_next.opt = s_reg.nv[NV_OPT_IDX];
        s_next.seq = SEQ_IDLE;
      end
      SEQ_IDLE, SEQ_ARMED, SEQ_READY: begin
        // Steps advance only on bus writes
      end
      default: begin
        // Lost code: restart from the first step
        s_next.seq = SEQ_IDLE;
      end
    endcase

    // Bus access, answered one cycle later
    if (access) begin
      s_next.ack = 1'b1;
      s_next.datOut = 32'h0000_0000;
      if (flashSel) begin
        // Flash space
        if (wr) begin
          // Plain writes never store into the array
          if (s_reg.seq == SEQ_IDLE) begin
            s_next.flAddr = flAdr;
            s_next.flData = wbDatI[7:0];
            s_next.seq = SEQ_ARMED;
          end else if (s_reg.seq != SEQ_LOAD) begin
            // Write out of turn breaks the sequence
            s_next.accErr = 1'b1;
            s_next.seq = SEQ_IDLE;
          end
        end else begin
          s_next.datOut = {24'h00_0000, flRead};
        end
      end else begin
        // Register space
        case (regOff)
          REG_CMD: begin
            s_next.datOut = {24'h00_0000, s_reg.cmd};
            if (wr && wbSelI[0]) begin
              // Code is taken only right after a flash write
              if (s_reg.seq == SEQ_ARMED) begin
                s_next.cmd = wbDatI[7:0];
                s_next.seq = SEQ_READY;
              end else if (s_reg.seq != SEQ_LOAD) begin
                s_next.accErr = 1'b1;
                s_next.seq = SEQ_IDLE;
              end
            end
          end
          REG_STATUS: begin
            // Flags read back as one byte
            s_next.datOut[ST_CBE_BIT] = s_reg.cbe;
            s_next.datOut[ST_CCF_BIT] = s_reg.ccf;
            s_next.datOut[ST_ACC_BIT] = s_reg.accErr;
            if (wr && wbSelI[0]) begin
              // Access error clears by writing one
              if (wbDatI[ST_ACC_BIT]) begin
                s_next.accErr = 1'b0;
              end
              if (wbDatI[ST_CBE_BIT] && s_reg.cbe) begin
                s_next.cbe = 1'b0;
                if (s_reg.seq != SEQ_READY) begin
                  // Launch without a full sequence
                  s_next.accErr = 1'b1;
                end else if (s_reg.cmd == CMD_ERASE_ABORT) begin
                  if (engLink.erasing) begin
                    s_next.engAbort = 1'b1;
                  end else if (!engLink.busy) begin
                    // Nothing to stop: quiet completion
                    s_next.runCmd = s_reg.cmd;
                    s_next.engStart = 1'b1;
                    s_next.ccf = 1'b0;
                  end else begin
                    // Abort during programming is ignored
                  end
                end else if (s_reg.cmd != CMD_SECTOR_ERASE &&
                    s_reg.cmd != CMD_PROGRAM) begin
                  // Unknown code
                  s_next.accErr = 1'b1;
                end else if (engLink.busy) begin
                  // Only an abort may join a running command
                  s_next.accErr = 1'b1;
                end else begin
                  s_next.runCmd = s_reg.cmd;
                  s_next.runAddr = s_reg.flAddr;
                  s_next.runData = s_reg.flData;
                  s_next.engStart = 1'b1;
                  s_next.ccf = 1'b0;
                end
                if (s_reg.seq != SEQ_LOAD) begin
                  s_next.seq = SEQ_IDLE;
                end
              end
            end
          end
          REG_IRQ_STAT: begin
            s_next.datOut[1:0] = s_reg.irqStat;
            if (wr && wbSelI[0]) begin
              // Write one to clear
              s_next.irqStat = s_reg.irqStat & ~wbDatI[1:0];
            end
          end
          REG_IRQ_MASK: begin
            // Plain read and write of the enables
            s_next.datOut[1:0] = s_reg.irqMask;
            if (wr && wbSelI[0]) begin
              s_next.irqMask = wbDatI[1:0];
            end
          end
          REG_PROT: begin
            // Read only; writes are dropped
            s_next.datOut[BYTE_W-1:0] = s_reg.prot;
          end
          REG_OPT: begin
            // Read only; writes are dropped
            s_next.datOut[BYTE_W-1:0] = s_reg.opt;
          end
          REG_KEY_LO: begin
            // Key is write only; each lane lands on its own
            if (wr) begin
              for (int b = 0; b < LANES; b++) begin
                if (wbSelI[b]) begin
                  s_next.key[BYTE_W*b +: BYTE_W] = wbDatI[BYTE_W*b +: BYTE_W];
                end
              end
            end
          end
          REG_KEY_HI: begin
            // Upper four bytes, same lane rule
            if (wr) begin
              for (int b = 0; b < LANES; b++) begin
                if (wbSelI[b]) begin
                  s_next.key[KEY_HI_LSB + BYTE_W*b +: BYTE_W] =
                    wbDatI[BYTE_W*b +: BYTE_W];
                end
              end
            end
          end
          REG_SECURE: begin
            // Read shows whether the key matched
            s_next.datOut[SECURE_BIT] = s_reg.unlocked;
            if (wr && wbSelI[CTRL_LANE] && wbDatI[SECURE_BIT]) begin
              // Compare only when the option allows it
              s_next.unlocked = s_reg.opt[OPT_BACKDOOR_BIT] &&
                (s_reg.key == s_reg.nv[KEY_BYTES-1:0]);
            end
          end
          default: begin
            // Unmapped: reads zero, writes ignored
            s_next.datOut = 32'h0000_0000;
          end
        endcase
      end
    end

    // Engine completion, after clears so a set wins
    if (engLink.done) begin
      s_next.ccf = 1'b1;
      if (engLink.cutShort) begin
        // Sector may be partly erased; array left as is
        s_next.accErr = 1'b1;
      end else if (s_reg.runCmd == CMD_SECTOR_ERASE) begin
        // Full erase of the area's sector wipes every byte
        if (s_reg.runAddr[15:SECTOR_LSB] == NV_BASE[15:SECTOR_LSB]) begin
          s_next.nv = {NV_DEPTH{NV_ERASED}};
        end
      end else if (s_reg.runCmd == CMD_PROGRAM) begin
        if (s_reg.runAddr[15:NV_AREA_LSB] == NV_BASE[15:NV_AREA_LSB]) begin
          // Programming only clears bits
          s_next.nv[s_reg.runAddr[NV_AREA_LSB-1:0]] =
            s_reg.nv[s_reg.runAddr[NV_AREA_LSB-1:0]] & s_reg.runData;
        end
      end
    end

    // Sticky events
    if (s_next.ccf && !s_reg.ccf) begin
      s_next.irqStat[IRQ_CCF_BIT] = 1'b1;
    end
    if (s_next.accErr && !s_reg.accErr) begin
      s_next.irqStat[IRQ_ACC_BIT] = 1'b1;
    end
    // Level interrupt from unmasked events
    s_next.irq = |(s_next.irqStat & s_next.irqMask);
  end

  // State register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      // Array starts erased; sequence starts by loading
      s_reg <= '{
        seq: SEQ_LOAD,
        ack: 1'b0,
        datOut: 32'h0000_0000,
        cmd: 8'h00,
        runCmd: 8'h00,
        runAddr: 16'h0000,
        runData: 8'h00,
        flAddr: 16'h0000,
        flData: 8'h00,
        cbe: 1'b1,
        ccf: 1'b1,
        accErr: 1'b0,
        irqStat: 2'h0,
        irqMask: 2'h0,
        irq: 1'b0,
        prot: 8'h00,
        opt: 8'h00,
        key: 64'h0000_0000_0000_0000,
        unlocked: 1'b0,
        engStart: 1'b0,
        engAbort: 1'b0,
        nv: {NV_DEPTH{NV_ERASED}}
      };
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs from flip-flops
  assign wbDatO = s_reg.datOut;
  assign wbAckO = s_reg.ack;
  assign irq = s_reg.irq;
endmodule : fse_sector_abort
`default_nettype wire

// ---- tb/fse_sector_abort_sva.sv ----
// Bus, read-back and interrupt checks for the abort sequencer
`timescale 1ns/10ps
`default_nettype none
module fse_sector_abort_sva import fse_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Wishbone side
  input wire logic [ADR_W-1:0] wbAdrI,
  input wire logic [31:0] wbDatI,
  input wire logic [3:0] wbSelI,
  input wire logic wbWeI,
  input wire logic wbCycI,
  input wire logic wbStbI,
  input wire logic [31:0] wbDatO,
  input wire logic wbAckO,
  // Interrupt
  input wire logic irq
);
  logic takeNow; // Request accepted at this edge
  logic [ADR_W-1:0] adrReg; // Address of last accepted request
  logic rdReg; // Last request was a read
  logic [1:0] datReg; // Low write bits of last request
  logic regRd; // Read answer from register space
  assign takeNow = wbCycI && wbStbI && !wbAckO;
  assign regRd = wbAckO && rdReg && !adrReg[FLASH_SEL_BIT];
  // Capture each accepted request
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      adrReg <= '0;
      rdReg <= 1'b0;
      datReg <= 2'h0;
    end else if (takeNow) begin
      adrReg <= wbAdrI;
      rdReg <= !wbWeI;
      datReg <= wbDatI[1:0];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_ack_next; takeNow |=> wbAckO; endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("ack missing one cycle after request");
  property p_ack_one; wbAckO |=> !wbAckO; endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("ack longer than one cycle");
  property p_ack_cause; wbAckO |-> $past(takeNow); endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_dat_hold; !wbAckO |-> $stable(wbDatO); endproperty
  a_dat_hold: assert property (p_dat_hold)
    else $error("read data moved without ack");
  property p_flash_erased;
    wbAckO && rdReg && adrReg[FLASH_SEL_BIT] && adrReg[17:6] != 12'hffb
      |-> wbDatO[7:0] == NV_ERASED;
  endproperty
  a_flash_erased: assert property (p_flash_erased)
    else $error("flash outside area not erased");
  property p_unmap_zero;
    regRd && adrReg[7:0] > REG_SECURE |-> wbDatO == 32'h0;
  endproperty
  a_unmap_zero: assert property (p_unmap_zero)
    else $error("unmapped read not zero");
  property p_key_hidden;
    regRd && adrReg[7:3] == 5'h03 |-> wbDatO == 32'h0;
  endproperty
  a_key_hidden: assert property (p_key_hidden)
    else $error("key register readable");
  property p_irq_reset; $rose(rst_b) |-> !irq ##1 !irq; endproperty
  a_irq_reset: assert property (p_irq_reset)
    else $error("irq high after reset");
  property p_mask_off;
    wbAckO && !rdReg && !adrReg[FLASH_SEL_BIT] &&
      adrReg[7:0] == REG_IRQ_MASK && datReg == 2'h0 |-> ##2 !irq;
  endproperty
  a_mask_off: assert property (p_mask_off)
    else $error("irq high with mask cleared");
endmodule : fse_sector_abort_sva
bind fse_sector_abort fse_sector_abort_sva u_sva (.clock(clock),
  .rst_b(rst_b), .wbAdrI(wbAdrI), .wbDatI(wbDatI), .wbSelI(wbSelI),
  .wbWeI(wbWeI), .wbCycI(wbCycI), .wbStbI(wbStbI), .wbDatO(wbDatO),
  .wbAckO(wbAckO), .irq(irq));
`default_nettype wire

// ---- tb/fse_sector_abort_tb_top.sv ----
// Self-checking bench for the sector erase abort sequencer
`timescale 1ns/10ps
`default_nettype none
module fse_sector_abort_tb_top import fse_pkg::*;;
  logic clock; // Bench clock
  logic rst_b; // Active-low reset
  logic [ADR_W-1:0] wbAdrI; // Bus address
  logic [31:0] wbDatI; // Write data
  logic [3:0] wbSelI; // Byte enables
  logic wbWeI, wbCycI, wbStbI; // Request
  logic [31:0] wbDatO; // Read data
  logic wbAckO; // Answer
  logic irq; // Interrupt
  int badCount; // Mismatches
  int checks; // Comparisons
  logic [7:0] seed; // Random state
  logic [31:0] rdData; // Last bus answer
  logic [7:0] progVal; // Random program byte
  fse_sector_abort u_dut (.clock(clock), .rst_b(rst_b), .wbAdrI(wbAdrI),
    .wbDatI(wbDatI), .wbSelI(wbSelI), .wbWeI(wbWeI), .wbCycI(wbCycI),
    .wbStbI(wbStbI), .wbDatO(wbDatO), .wbAckO(wbAckO), .irq(irq));
  // Clock generator
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Next random byte
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  // Expected status: buffer empty, complete, given error flag
  function automatic logic [31:0] stat(input logic acc);
    logic [31:0] r;
    r = 32'h0;
    r[ST_CBE_BIT] = 1'b1;
    r[ST_CCF_BIT] = 1'b1;
    r[ST_ACC_BIT] = acc;
    return r;
  endfunction : stat
  // Counts and verdict
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, badCount);
    if (badCount == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop
  // Compare seen against expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      badCount++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One classic bus cycle, bounded wait for ack
  task automatic xfer(input logic we, input logic [ADR_W-1:0] adr,
    input logic [31:0] dat);
    int n;
    @(posedge clock);
    wbCycI <= 1'b1;
    wbStbI <= 1'b1;
    wbWeI <= we;
    wbAdrI <= adr;
    wbDatI <= dat;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (wbAckO !== 1'b1 && n < 20);
    rdData = wbDatO;
    wbCycI <= 1'b0;
    wbStbI <= 1'b0;
    if (wbAckO !== 1'b1) begin
      badCount++;
      report_and_stop();
    end
  endtask : xfer
  // Register and flash accesses
  task automatic regWr(input logic [7:0] off, input logic [31:0] d);
    xfer(1'b1, {11'h0, off}, d);
  endtask : regWr
  task automatic regRd(input logic [7:0] off);
    xfer(1'b0, {11'h0, off}, 32'h0);
  endtask : regRd
  task automatic flWr(input logic [15:0] a, input logic [7:0] d);
    xfer(1'b1, {1'b1, a, 2'b00}, {24'h0, d});
  endtask : flWr
  task automatic flRd(input logic [15:0] a);
    xfer(1'b0, {1'b1, a, 2'b00}, 32'h0);
  endtask : flRd
  // Full command sequence
  task automatic cmd(input logic [15:0] a, input logic [7:0] d,
    input logic [7:0] code);
    flWr(a, d);
    regWr(REG_CMD, {24'h0, code});
    regWr(REG_STATUS, 32'h80);
  endtask : cmd
  // Poll status until complete, bounded
  task automatic waitDone(input int lim);
    int n;
    n = 0;
    do begin
      regRd(REG_STATUS);
      n++;
    end while (rdData[ST_CCF_BIT] !== 1'b1 && n < lim);
    if (rdData[ST_CCF_BIT] !== 1'b1) begin
      badCount++;
      report_and_stop();
    end
  endtask : waitDone
  // Main sequence
  initial begin
    rst_b = 1'b0;
    wbAdrI = '0;
    wbDatI = 32'h0;
    wbSelI = 4'hf;
    wbWeI = 1'b0;
    wbCycI = 1'b0;
    wbStbI = 1'b0;
    badCount = 0;
    checks = 0;
    seed = 8'h1c;
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    repeat (2) @(posedge clock);
    regRd(REG_PROT);
    chk(rdData, 32'hff);
    regRd(REG_OPT);
    chk(rdData, 32'hff);
    regRd(8'h24);
    chk(rdData, 32'h0);
    flRd(16'h1234);
    chk(rdData, {24'h0, NV_ERASED});
    // Abort with nothing running
    cmd(16'h0100, seed, CMD_ERASE_ABORT);
    waitDone(4);
    chk(rdData, stat(1'b0));
    // Program a random byte, then cut an erase of its sector
    seed = lfsr(seed);
    progVal = seed;
    cmd(NV_BASE, progVal, CMD_PROGRAM);
    waitDone(1000);
    flRd(NV_BASE);
    chk(rdData, {24'h0, progVal});
    regWr(REG_IRQ_STAT, 32'h3);
    cmd(NV_BASE + 16'h5, 8'h0, CMD_SECTOR_ERASE);
    seed = lfsr(seed);
    repeat (seed) @(posedge clock);
    cmd(16'h2000, seed, CMD_ERASE_ABORT);
    waitDone(4);
    chk(rdData, stat(1'b1));
    flRd(NV_BASE);
    chk(rdData, {24'h0, progVal});
    // Events raised while masked, interrupt unmasked, then cleared
    regRd(REG_IRQ_STAT);
    chk(rdData, 32'h3);
    chk({31'h0, irq}, 32'h0);
    regWr(REG_IRQ_MASK, 32'h2);
    regRd(REG_IRQ_MASK);
    chk({31'h0, irq}, 32'h1);
    regWr(REG_IRQ_STAT, 32'h3);
    regRd(REG_IRQ_STAT);
    chk({31'h0, irq}, 32'h0);
    regWr(REG_STATUS, 32'h10);
    regRd(REG_STATUS);
    chk(rdData, stat(1'b0));
    // Fresh erase runs to its end
    cmd(NV_BASE, 8'h0, CMD_SECTOR_ERASE);
    waitDone(2000);
    chk(rdData, stat(1'b0));
    flRd(NV_BASE);
    chk(rdData, {24'h0, NV_ERASED});
    // Abort seen by the engine on its last erase count
    cmd(NV_BASE, progVal, CMD_PROGRAM);
    waitDone(1000);
    cmd(NV_BASE, 8'h0, CMD_SECTOR_ERASE);
    // Eight bus edges separate the end of this wait from the abort launch, nine from the engine taking it
    repeat (ERASE_CYCLES - 12'd9) @(posedge clock);
    cmd(16'h0300, seed, CMD_ERASE_ABORT);
    waitDone(4);
    chk(rdData, stat(1'b0));
    flRd(NV_BASE);
    chk(rdData, {24'h0, NV_ERASED});
    // Out-of-order step and unknown code raise access error
    regWr(REG_CMD, {24'h0, CMD_ERASE_ABORT});
    regRd(REG_STATUS);
    chk(rdData, stat(1'b1));
    regWr(REG_STATUS, 32'h10);
    cmd(16'h0400, seed, 8'h55);
    regRd(REG_STATUS);
    chk(rdData, stat(1'b1));
    regWr(REG_STATUS, 32'h10);
    // Backdoor key, wrong then right
    regWr(REG_KEY_LO, 32'h0);
    regWr(REG_KEY_HI, 32'hffffffff);
    regWr(REG_SECURE, 32'h1);
    regRd(REG_SECURE);
    chk(rdData, 32'h0);
    regWr(REG_KEY_LO, 32'hffffffff);
    regWr(REG_SECURE, 32'h1);
    regRd(REG_SECURE);
    chk(rdData, 32'h1);
    regRd(REG_KEY_LO);
    chk(rdData, 32'h0);
    // Lone flash write leaves the area erased
    regWr(REG_IRQ_MASK, 32'h0);
    flWr(NV_BASE + 16'h1, seed);
    flRd(NV_BASE + 16'h1);
    chk(rdData, {24'h0, NV_ERASED});
    report_and_stop();
  end
endmodule : fse_sector_abort_tb_top
`default_nettype wire
